/* File: core/atf_task_file.sv */
/*
  Task-file register bank of the storage card: error/feature, block count,
  start address bytes, unit/address-top, status, shadow status and host
  control. Assumes host strobes arrive one cycle wide on the card clock and
  the command engine drives its status and event inputs on that clock.
*/
// How it works
// - Error register bits 7,6,4,2,0; 5,3,1 zero
// - Abort flag sets on aborted command
// - Error reads, feature writes share offset 1/Dh
// - PC Card offset 0 high-lane read gives error
// - PC Card offset 0 high-lane write loads feature
// - Count zero means 256 blocks
// - Count zero on success, remaining otherwise
// - Linear address from three bytes plus heads
// - Bit 6 picks linear or geometry addressing
// - Unit bit 4 selects card number
// - Busy locks host out, masks other status
// - Status read clears interrupt, shadow not
// - DMA request only while busy or request
// - Ready clear until engine can accept
// - Status bit 5 fault, bit 4 seek done
// - Status bit 3 asks data transfer
// - Corrected flag set, read continues
// - Error flag; bit 1 zero; failing address kept
// - Control writable while busy, unused bits ignored
// - Soft reset held while control bit 2 set
// - Bit 1 disables interrupts, zero after reset
`timescale 1ns/1ns

module atf_task_file
  import atf_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          rst,
  input  wire atf_host_req_t host_req,
  input  wire atf_engine_t   engine,
  output logic [15:0]        host_rdata,
  output logic               irq_out,
  output logic               dma_request,
  output logic               soft_reset_out,
  output logic               linear_addr_select,
  output logic               card_number_bit,
  output logic [3:0]         head_number,
  output logic [27:0]        linear_addr,
  output logic [8:0]         blocks_requested,
  output logic [7:0]         feature_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  atf_state_t st_r;
  atf_state_t st_nxt;

  logic [7:0] status_now;
  logic       hi_lane_only;
  logic       lo_lane;
  logic       host_locked;

  // Assemble the live status byte; while busy other bits read zero
  always_comb
  begin
    status_now = ATF_BYTE_ZERO;
    status_now[ATF_ST_BSY] = engine.busy;
    if (!engine.busy)
    begin
      status_now[ATF_ST_RDY]  = engine.ready;
      status_now[ATF_ST_DWF]  = st_r.write_fault_flag;
      status_now[ATF_ST_DSC]  = engine.seek_done;
      status_now[ATF_ST_DRQ]  = engine.data_request;
      status_now[ATF_ST_CORRECTED_DATA_FLAG] = st_r.corrected_data_flag;
      status_now[ATF_ST_ERR]  = st_r.errf;
    end
  end

  // Lane decode for PC Card byte accesses
  assign hi_lane_only = host_req.pc_card && host_req.low_byte_enable_n
                        && !host_req.high_byte_enable_n;
  assign lo_lane      = !host_req.low_byte_enable_n;
  // Host may not touch command registers while the card owns them
  assign host_locked  = engine.busy;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    st_nxt = st_r;
    // Reads: error on low lane at 1/Dh, or high lane at offset 0
    if (host_req.rd)
    begin
      st_nxt.rdata = 16'h0000;
      case (host_req.offset)
        ATF_OFF_DATA:
        begin
          if (hi_lane_only)
            st_nxt.rdata[15:8] = st_r.err & ATF_ERR_MASK;
        end
        ATF_OFF_ERRFEA, ATF_OFF_ERRDUP:
        begin
          if (hi_lane_only)
            st_nxt.rdata[15:8] = st_r.err & ATF_ERR_MASK;
          else
            st_nxt.rdata[7:0]  = st_r.err & ATF_ERR_MASK;
        end
        ATF_OFF_COUNT: st_nxt.rdata[7:0] = st_r.count;
        ATF_OFF_ADDR0: st_nxt.rdata[7:0] = st_r.addr0;
        ATF_OFF_ADDR1: st_nxt.rdata[7:0] = st_r.addr1;
        ATF_OFF_ADDR2: st_nxt.rdata[7:0] = st_r.addr2;
        ATF_OFF_UNIT:  st_nxt.rdata[7:0] = st_r.unit;
        ATF_OFF_COND, ATF_OFF_CTRL: st_nxt.rdata[7:0] = status_now;
        default:       st_nxt.rdata = 16'h0000;
      endcase
    end

    // Host writes to the command block, refused while busy
    if (host_req.wr && !host_locked && !st_r.soft_reset)
    begin
      case (host_req.offset)
        ATF_OFF_DATA:
        begin
          if (hi_lane_only)
            st_nxt.feature = host_req.wdata[15:8];
        end
        ATF_OFF_ERRFEA, ATF_OFF_ERRDUP:
        begin
          if (hi_lane_only)
            st_nxt.feature = host_req.wdata[15:8];
          else if (lo_lane || !host_req.pc_card)
            st_nxt.feature = host_req.wdata[7:0];
        end
        ATF_OFF_COUNT: st_nxt.count = host_req.wdata[7:0];
        ATF_OFF_ADDR0: st_nxt.addr0 = host_req.wdata[7:0];
        ATF_OFF_ADDR1: st_nxt.addr1 = host_req.wdata[7:0];
        ATF_OFF_ADDR2: st_nxt.addr2 = host_req.wdata[7:0];
        // Bits 7 and 5 are stored as written and not used
        ATF_OFF_UNIT:  st_nxt.unit  = host_req.wdata[7:0];
        default: ;
      endcase
    end

    // Control register accepted at any time, only bits 2 and 1 kept
    if (host_req.wr && host_req.offset == ATF_OFF_CTRL)
    begin
      st_nxt.soft_reset  = host_req.wdata[ATF_CTL_SRST];
      st_nxt.irq_disable = host_req.wdata[ATF_CTL_NIEN];
    end

    // Engine progress: error clear at start, block count, failing address
    if (engine.cmd_start)
    begin
      st_nxt.err  = ATF_BYTE_ZERO;
      st_nxt.write_fault_flag  = 1'b0;
      st_nxt.corrected_data_flag = 1'b0;
      st_nxt.errf = 1'b0;
    end
    if (engine.sector_done)
      st_nxt.count = st_r.count - ATF_COUNT_ONE;
    if (engine.cmd_ok)
      st_nxt.count = ATF_BYTE_ZERO;
    if (engine.addr_load)
    begin
      st_nxt.addr0 = engine.addr_value[7:0];
      st_nxt.addr1 = engine.addr_value[15:8];
      st_nxt.addr2 = engine.addr_value[23:16];
      st_nxt.unit[ATF_UNIT_HSHI:0] = engine.addr_value[27:24];
    end

    // Error causes; sets come after the command-start clear
    if (engine.set_bad_block)     st_nxt.err[ATF_ERR_BBK]  = 1'b1;
    if (engine.set_uncorrectable) st_nxt.err[ATF_ERR_UNC]  = 1'b1;
    if (engine.set_id_missing)    st_nxt.err[ATF_ERR_SECTOR_ID_MISSING_FLAG] = 1'b1;
    if (engine.set_abort)         st_nxt.err[ATF_ERR_COMMAND_ABORT_FLAG] = 1'b1;
    if (engine.set_general)       st_nxt.err[ATF_ERR_GEN]  = 1'b1;
    if (engine.set_write_fault)   st_nxt.write_fault_flag  = 1'b1;
    if (engine.set_corrected)     st_nxt.corrected_data_flag = 1'b1;
    if (engine.cmd_fail)          st_nxt.errf = 1'b1;

    // Pending interrupt: status read clears, new event wins
    if (host_req.rd && host_req.offset == ATF_OFF_COND)
      st_nxt.irq_pend = 1'b0;
    if (engine.irq_event)
      st_nxt.irq_pend = 1'b1;

    // Soft reset returns the command block, except the feature register, to its idle values
    if (st_r.soft_reset)
    begin
      st_nxt.err      = ATF_BYTE_ZERO;
      st_nxt.count    = ATF_COUNT_ONE;
      st_nxt.addr0    = ATF_COUNT_ONE;
      st_nxt.addr1    = ATF_BYTE_ZERO;
      st_nxt.addr2    = ATF_BYTE_ZERO;
      st_nxt.unit     = ATF_UNIT_RESET;
      st_nxt.write_fault_flag      = 1'b0;
      st_nxt.corrected_data_flag     = 1'b0;
      st_nxt.errf     = 1'b0;
      st_nxt.irq_pend = 1'b0;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      st_r <= '0;
      st_r.count <= ATF_COUNT_ONE;
      st_r.addr0 <= ATF_COUNT_ONE;
      st_r.unit  <= ATF_UNIT_RESET;
      st_r.irq_disable <= 1'b0;
    end
    else
      st_r <= st_nxt;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign host_rdata         = st_r.rdata;
  assign irq_out            = st_r.irq_pend && !st_r.irq_disable;
  assign dma_request        = engine.dma_want &&
                              (engine.busy || engine.data_request);
  assign soft_reset_out     = st_r.soft_reset;
  assign linear_addr_select = st_r.unit[ATF_UNIT_LBA];
  assign card_number_bit    = st_r.unit[ATF_UNIT_CARD];
  assign head_number        = st_r.unit[ATF_UNIT_HSHI:0];
  assign linear_addr        = {st_r.unit[ATF_UNIT_HSHI:0], st_r.addr2,
                               st_r.addr1, st_r.addr0};
  assign blocks_requested   = (st_r.count == ATF_BYTE_ZERO) ?
                              ATF_COUNT_FULL : {1'b0, st_r.count};
  assign feature_out        = st_r.feature;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_err_zero_bits: assert property (@(posedge clock) disable iff (rst)
    $rose(host_req.rd) ##0 (host_req.offset == ATF_OFF_ERRFEA) |=>
      (host_rdata[5] == 1'b0 && host_rdata[3] == 1'b0
       && host_rdata[1] == 1'b0))
    else $error("Error register reserved bit set");

  a_abort_sets: assert property (@(posedge clock) disable iff (rst)
    engine.set_abort && !st_r.soft_reset |=> st_r.err[ATF_ERR_COMMAND_ABORT_FLAG])
    else $error("Abort flag not set");

  a_count_full: assert property (@(posedge clock) disable iff (rst)
    (st_r.count == ATF_BYTE_ZERO) |-> blocks_requested == ATF_COUNT_FULL)
    else $error("Zero count not 256");

  a_count_done: assert property (@(posedge clock) disable iff (rst)
    engine.cmd_ok && !st_r.soft_reset |=> st_r.count == ATF_BYTE_ZERO)
    else $error("Count not zero after success");

  a_busy_masks: assert property (@(posedge clock) disable iff (rst)
    host_req.rd && engine.busy && host_req.offset == ATF_OFF_COND
    |=> host_rdata[6:0] == 7'h00 && host_rdata[7])
    else $error("Status not masked while busy");

  a_irq_clear: assert property (@(posedge clock) disable iff (rst)
    host_req.rd && host_req.offset == ATF_OFF_COND && !engine.irq_event
    |=> !irq_out)
    else $error("Status read left interrupt");

  a_shadow_keep: assert property (@(posedge clock) disable iff (rst)
    host_req.rd && host_req.offset == ATF_OFF_CTRL && st_r.irq_pend
    && !st_r.soft_reset |=> st_r.irq_pend)
    else $error("Shadow read cleared interrupt");

  a_dma_gate: assert property (@(posedge clock) disable iff (rst)
    dma_request |-> (engine.busy || engine.data_request))
    else $error("DMA request without busy or request");

  a_ctrl_busy: assert property (@(posedge clock) disable iff (rst)
    host_req.wr && host_req.offset == ATF_OFF_CTRL
    |=> soft_reset_out == $past(host_req.wdata[ATF_CTL_SRST]))
    else $error("Control write lost");

  a_irq_mask: assert property (@(posedge clock) disable iff (rst)
    st_r.irq_disable |-> !irq_out)
    else $error("Interrupt not masked");

endmodule : atf_task_file

/* File: core/atf_pkg.sv */
/*
  Package for the task-file register bank: register offsets, bit positions,
  reset values and the carrier structs shared with the host-side access port.
  Assumes the host access has already been resolved to a 4-bit offset and
  two byte-lane enables by the pin-level logic of the card.
*/
package atf_pkg;

  // ****************************************************************
  // Register offsets (4-bit task-file offset)
  // ****************************************************************
  localparam logic [3:0] ATF_OFF_DATA   = 4'h0;
  localparam logic [3:0] ATF_OFF_ERRFEA = 4'h1;
  localparam logic [3:0] ATF_OFF_COUNT  = 4'h2;
  localparam logic [3:0] ATF_OFF_ADDR0  = 4'h3;
  localparam logic [3:0] ATF_OFF_ADDR1  = 4'h4;
  localparam logic [3:0] ATF_OFF_ADDR2  = 4'h5;
  localparam logic [3:0] ATF_OFF_UNIT   = 4'h6;
  localparam logic [3:0] ATF_OFF_COND   = 4'h7;
  localparam logic [3:0] ATF_OFF_ERRDUP = 4'hd;
  localparam logic [3:0] ATF_OFF_CTRL   = 4'he;

  // ****************************************************************
  // Error register bits
  // ****************************************************************
  localparam int ATF_ERR_BBK  = 7;
  localparam int ATF_ERR_UNC  = 6;
  localparam int ATF_ERR_SECTOR_ID_MISSING_FLAG = 4;
  localparam int ATF_ERR_COMMAND_ABORT_FLAG = 2;
  localparam int ATF_ERR_GEN  = 0;
  localparam logic [7:0] ATF_ERR_MASK = 8'hd5;

  // ****************************************************************
  // Unit/address-top register bits
  // ****************************************************************
  localparam int ATF_UNIT_LBA  = 6;
  localparam int ATF_UNIT_CARD = 4;
  localparam int ATF_UNIT_HSHI = 3;
  localparam logic [7:0] ATF_UNIT_RESET = 8'ha0;

  // ****************************************************************
  // Status register bits
  // ****************************************************************
  localparam int ATF_ST_BSY  = 7;
  localparam int ATF_ST_RDY  = 6;
  localparam int ATF_ST_DWF  = 5;
  localparam int ATF_ST_DSC  = 4;
  localparam int ATF_ST_DRQ  = 3;
  localparam int ATF_ST_CORRECTED_DATA_FLAG = 2;
  localparam int ATF_ST_ERR  = 0;

  // ****************************************************************
  // Host control register bits
  // ****************************************************************
  localparam int ATF_CTL_SRST = 2;
  localparam int ATF_CTL_NIEN = 1;

  localparam logic [7:0] ATF_BYTE_ZERO  = 8'h00;
  localparam logic [7:0] ATF_COUNT_ONE  = 8'h01;
  localparam logic [8:0] ATF_COUNT_FULL = 9'h100;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic        rd;        // One-cycle read strobe
    logic        wr;        // One-cycle write strobe
    logic [3:0]  offset;    // Task-file offset
    logic        low_byte_enable_n;
    logic        high_byte_enable_n;
    logic        pc_card;   // PC Card modes when high
    logic [15:0] wdata;
  } atf_host_req_t;

  typedef struct packed {
    logic       set_bad_block;
    logic       set_uncorrectable;
    logic       set_id_missing;
    logic       set_abort;
    logic       set_general;
    logic       set_write_fault;
    logic       set_corrected;
    logic       cmd_start;     // Clears error state for a new command
    logic       busy;
    logic       ready;
    logic       seek_done;
    logic       data_request;
    logic       dma_want;      // Engine wants a DMA transfer
    logic       sector_done;   // One sector moved
    logic       cmd_ok;        // Command finished without error
    logic       cmd_fail;      // Command finished with error
    logic       irq_event;     // Engine raises an interrupt
    logic       addr_load;     // Store failing sector address
    logic [27:0] addr_value;
  } atf_engine_t;

  typedef struct packed {
    logic [7:0] err;
    logic [7:0] feature;
    logic [7:0] count;
    logic [7:0] addr0;
    logic [7:0] addr1;
    logic [7:0] addr2;
    logic [7:0] unit;
    logic       write_fault_flag;
    logic       corrected_data_flag;
    logic       errf;
    logic       soft_reset;
    logic       irq_disable;
    logic       irq_pend;
    logic [15:0] rdata;
  } atf_state_t;

endpackage : atf_pkg

/* File: dv/atf_host_model.sv */
/*
  Host-side bus model: byte reads and writes of the task file.
  Assumes its tasks are called at a falling clock edge.
*/
`timescale 1ns/1ns
module atf_host_model
  import atf_pkg::*;
(
  input  wire logic     clock,
  output atf_host_req_t req
);
  // Idle bus: no strobe, lanes carry junk
  initial
  begin
    req = '0;
    req.wdata = 16'h5a5a;
  end

  // One byte access; the unused lane carries the inverse byte
  task automatic access(input logic w, input logic [3:0] o,
                        input logic [7:0] d, input logic hl);
    logic [7:0] b;
    b = d;
    if (w && o == ATF_OFF_UNIT) b = b | 8'ha0;
    if (w && o == ATF_OFF_CTRL) b = b & 8'h06;
    req.offset = o;
    req.pc_card = hl;
    req.low_byte_enable_n = hl;
    req.high_byte_enable_n = ~hl;
    req.wdata = hl ? {b, ~b} : {~b, b};
    req.wr = w;
    req.rd = ~w;
    @(negedge clock);
    req.wr = 1'b0;
    req.rd = 1'b0;
    req.offset = ~o;
    req.wdata = ~req.wdata;
    @(negedge clock);
  endtask : access
endmodule : atf_host_model

/* File: dv/test_ata_task_file_registers.sv */
/*
  Self-checking bench of the task-file register bank.
  Assumes the host model above and the engine levels driven here.
*/
`timescale 1ns/1ns
module test_ata_task_file_registers
  import atf_pkg::*;
;
  logic          clock = 1'b0;
  logic          rst = 1'b1;
  atf_host_req_t host_req;
  atf_engine_t   eng = '0;
  logic [15:0]   host_rdata;
  logic          irq_out, dma_request, soft_reset_out, lin_sel, card_bit;
  logic [3:0]    head;
  logic [27:0]   lin;
  logic [8:0]    blocks;
  logic [7:0]    feature;
  logic [7:0]    r [2:6];
  logic [31:0]   expq [$];
  logic          rd_seen = 1'b0;
  int            n_fail = 0;
  int            checks_done = 0;
  int            seed = 32'h21483683;

  atf_host_model host (.clock(clock), .req(host_req));

  atf_task_file uut (.clock(clock), .rst(rst), .host_req(host_req),
    .engine(eng), .host_rdata(host_rdata), .irq_out(irq_out),
    .dma_request(dma_request), .soft_reset_out(soft_reset_out),
    .linear_addr_select(lin_sel), .card_number_bit(card_bit),
    .head_number(head), .linear_addr(lin), .blocks_requested(blocks),
    .feature_out(feature));

  always #50 clock = ~clock;

  // ****************************************************************
  // Compare and report
  // ****************************************************************
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  task automatic check_sig(input string nm, input logic [27:0] e,
                           input logic [27:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : check_sig

  task automatic check_rd(input logic [15:0] g);
    logic [31:0] n;
    n = (expq.size() > 0) ? expq.pop_front() : 32'hffff_dead;
    checks_done++;
    if ((g & n[31:16]) !== n[15:0])
    begin
      n_fail++;
      $display("mismatch read_data expected %h seen %h", n[15:0], g);
    end
  endtask : check_rd

  // Read results land one cycle after the read strobe
  always @(posedge clock) rd_seen <= host_req.rd;
  always @(negedge clock)
  begin
    if (rd_seen === 1'b1)
      check_rd(host_rdata);
  end

  // ****************************************************************
  // Stimulus helpers
  // ****************************************************************
  task automatic wr(input logic [3:0] o, input logic [7:0] d,
                    input logic hl = 1'b0);
    host.access(1'b1, o, d, hl);
  endtask : wr

  task automatic rchk(input logic [3:0] o, input logic [7:0] e,
                      input logic hl = 1'b0, input logic any = 1'b0);
    expq.push_back(any ? 32'h0 : hl ? {16'hff00, e, 8'h00}
                                    : {16'h00ff, 8'h00, e});
    host.access(1'b0, o, 8'h00, hl);
  endtask : rchk

  task automatic ep(input atf_engine_t p);
    eng = eng | p;
    @(negedge clock);
    eng = eng & ~p;
    @(negedge clock);
  endtask : ep

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial
  begin
    repeat (3) @(negedge clock);
    rst = 1'b0;
    rchk(ATF_OFF_COND, 8'h00);
    rchk(ATF_OFF_COUNT, 8'h01);
    rchk(ATF_OFF_UNIT, 8'ha0);
    check_sig("irq", 28'h0, {27'h0, irq_out});
    // Both addressing modes and card numbers, random contents
    for (int p = 0; p < 2; p++)
    begin
      for (int o = 2; o <= 6; o++)
      begin
        r[o] = 8'($random(seed));
        if (o == 6) r[o] = {1'b1, p[0], 1'b1, p[0], r[o][3:0]};
        wr(4'(o), r[o]);
        rchk(4'(o), r[o]);
      end
      check_sig("linear", {r[6][3:0], r[5], r[4], r[3]}, lin);
      check_sig("lin_sel", {27'h0, p[0]}, {27'h0, lin_sel});
      check_sig("card", {27'h0, p[0]}, {27'h0, card_bit});
      check_sig("head", {24'h0, r[6][3:0]}, {24'h0, head});
      check_sig("blocks", {19'h0, r[2] == 8'h00, r[2]}, {19'h0, blocks});
    end
    wr(ATF_OFF_COUNT, 8'h00);
    check_sig("blocks", 28'h100, {19'h0, blocks});
    wr(ATF_OFF_ERRFEA, 8'h3c);
    check_sig("feature", 28'h3c, {20'h0, feature});
    wr(ATF_OFF_ERRDUP, 8'hc3);
    check_sig("feature", 28'hc3, {20'h0, feature});
    wr(ATF_OFF_DATA, 8'h5a, 1'b1);
    check_sig("feature", 28'h5a, {20'h0, feature});
    // Error flags
    ep(atf_engine_t'{set_bad_block: 1, set_uncorrectable: 1,
       set_id_missing: 1, set_abort: 1, set_general: 1, default: 0});
    rchk(ATF_OFF_ERRFEA, 8'hd5);
    rchk(ATF_OFF_ERRDUP, 8'hd5);
    rchk(ATF_OFF_DATA, 8'hd5, 1'b1);
    ep(atf_engine_t'{cmd_start: 1, default: 0});
    ep(atf_engine_t'{set_abort: 1, default: 0});
    rchk(ATF_OFF_ERRFEA, 8'h04);
    // Status bits, busy masking and lockout, DMA request
    eng.ready = 1'b1;
    eng.seek_done = 1'b1;
    eng.data_request = 1'b1;
    ep(atf_engine_t'{set_write_fault: 1, set_corrected: 1, cmd_fail: 1,
       set_general: 1, default: 0});
    rchk(ATF_OFF_COND, 8'h7d);
    rchk(ATF_OFF_CTRL, 8'h7d);
    wr(ATF_OFF_COUNT, 8'h21);
    eng.data_request = 1'b0;
    eng.dma_want = 1'b1;
    @(negedge clock);
    check_sig("dma", 28'h0, {27'h0, dma_request});
    eng.busy = 1'b1;
    @(negedge clock);
    check_sig("dma", 28'h1, {27'h0, dma_request});
    rchk(ATF_OFF_COND, 8'h80);
    wr(ATF_OFF_COUNT, 8'h77);
    eng.busy = 1'b0;
    eng.data_request = 1'b1;
    @(negedge clock);
    check_sig("dma", 28'h1, {27'h0, dma_request});
    rchk(ATF_OFF_COUNT, 8'h21);
    eng = '0;
    // Interrupt pending, masking and clearing
    wr(ATF_OFF_CTRL, 8'h00);
    ep(atf_engine_t'{irq_event: 1, default: 0});
    check_sig("irq", 28'h1, {27'h0, irq_out});
    rchk(ATF_OFF_CTRL, 8'h00, 1'b0, 1'b1);
    check_sig("irq", 28'h1, {27'h0, irq_out});
    rchk(ATF_OFF_COND, 8'h00, 1'b0, 1'b1);
    check_sig("irq", 28'h0, {27'h0, irq_out});
    wr(ATF_OFF_CTRL, 8'h02);
    ep(atf_engine_t'{irq_event: 1, default: 0});
    check_sig("irq", 28'h0, {27'h0, irq_out});
    wr(ATF_OFF_CTRL, 8'h00);
    check_sig("irq", 28'h1, {27'h0, irq_out});
    rchk(ATF_OFF_COND, 8'h00, 1'b0, 1'b1);
    // Soft reset entered while busy
    eng.busy = 1'b1;
    wr(ATF_OFF_CTRL, 8'h04);
    check_sig("soft", 28'h1, {27'h0, soft_reset_out});
    eng.busy = 1'b0;
    wr(ATF_OFF_COUNT, 8'h09);
    rchk(ATF_OFF_COUNT, 8'h01);
    wr(ATF_OFF_CTRL, 8'h00);
    check_sig("soft", 28'h0, {27'h0, soft_reset_out});
    // Count left at completion, failing address
    wr(ATF_OFF_COUNT, 8'h03);
    ep(atf_engine_t'{sector_done: 1, default: 0});
    ep(atf_engine_t'{sector_done: 1, default: 0});
    ep(atf_engine_t'{cmd_fail: 1, default: 0});
    rchk(ATF_OFF_COUNT, 8'h01);
    wr(ATF_OFF_COUNT, 8'h02);
    ep(atf_engine_t'{cmd_ok: 1, default: 0});
    rchk(ATF_OFF_COUNT, 8'h00);
    ep(atf_engine_t'{addr_load: 1, addr_value: 28'h9876543, default: 0});
    rchk(ATF_OFF_ADDR1, 8'h65);
    check_sig("linear", 28'h9876543, lin);
    repeat (4) @(negedge clock);
    check_sig("pending", 28'h0, 28'(expq.size()));
    tally_and_finish();
  end

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clock);
    n_fail++;
    $display("mismatch run expected done seen timeout");
    tally_and_finish();
  end
endmodule : test_ata_task_file_registers
